// ---- pkg/cfgio_defines.svh ----
`ifndef CFGIO_DEFINES_SVH
`define CFGIO_DEFINES_SVH

// register indexes on the configuration port
`define CFGIO_IDX_FSEL_LAST 4'h5
`define CFGIO_IDX_ELEC      4'h6
`define CFGIO_IDX_ANALOG    4'h7
`define CFGIO_IDX_POL       4'h8
`define CFGIO_IDX_CLKDIV    4'h9
`define CFGIO_IDX_PINLVL    4'ha

// reset values, also forced during deep sleep
`define CFGIO_RST_FSEL0  8'h00
`define CFGIO_RST_FSEL1  8'h27
`define CFGIO_RST_FSEL2  8'h28
`define CFGIO_RST_FSEL3  8'h29
`define CFGIO_RST_FSEL4  8'h2a
`define CFGIO_RST_FSEL5  8'h90
`define CFGIO_RST_ELEC   7'h00
`define CFGIO_RST_ANALOG 2'h0
`define CFGIO_RST_POL    6'h3f

// field positions
`define CFGIO_DIR_BIT   7
`define CFGIO_DRIVE_BIT 6

// function codes
`define CFGIO_C_CLK       7'h00
`define CFGIO_C_EXC_FIRST 7'h01
`define CFGIO_C_EXC_LAST  7'h18
`define CFGIO_C_CHAN_A    7'h21
`define CFGIO_C_CHAN_B    7'h22
`define CFGIO_C_NCHAN_A   7'h23
`define CFGIO_C_NCHAN_B   7'h24
`define CFGIO_C_RX_ERR    7'h25
`define CFGIO_C_GEN_ERR   7'h26
`define CFGIO_C_RXQ_NE    7'h27
`define CFGIO_C_RXQ_THR   7'h28
`define CFGIO_C_CCA       7'h29
`define CFGIO_C_SFD       7'h2a
`define CFGIO_C_LOW       7'h7e

// predefined exception groups (flag index = code - 1)
`define CFGIO_RX_ERR_MASK  24'h600060
`define CFGIO_GEN_ERR_MASK 24'h0f0000

// clock output timing
`define CFGIO_SYS_HZ     100000000
`define CFGIO_CLK_OUT_HZ 1000000
`define CFGIO_CLK_HALF   (`CFGIO_SYS_HZ / (2 * `CFGIO_CLK_OUT_HZ))

`endif

// ---- pkg/cfgio_pkg.sv ----
package cfgio_pkg;

    typedef logic [6:0] cfgio_code_type;

    // strobe numbering, equal to the input function code
    typedef enum logic [3:0] {
        CFGIO_S_EXEC_BUF   = 4'h0,
        CFGIO_S_MASK_CLR   = 4'h1,
        CFGIO_S_MASK_SET   = 4'h2,
        CFGIO_S_RX_ON      = 4'h3,
        CFGIO_S_SAMPLE_CCA = 4'h4,
        CFGIO_S_ACK        = 4'h5,
        CFGIO_S_ACK_PEND   = 4'h6,
        CFGIO_S_NACK       = 4'h7,
        CFGIO_S_TX_ON      = 4'h8,
        CFGIO_S_TX_ON_CCA  = 4'h9,
        CFGIO_S_FLUSH_RX   = 4'ha,
        CFGIO_S_FLUSH_TX   = 4'hb,
        CFGIO_S_POP_RX     = 4'hc,
        CFGIO_S_TX_CAL     = 4'hd,
        CFGIO_S_RADIO_OFF  = 4'he,
        CFGIO_S_OSC_OFF    = 4'hf
    } cfgio_strobe_type;

endpackage

// ---- design/cfgio_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cfgio_defines.svh"
// Function
// - six pins, each input or output, each with its own pull-up enable
// - function-select bit 7 high makes the pin an input, low an output
// - shared config holds pull-ups, one extra-drive bit, analog select pins 0-1
// - reset pin setup applies in deep sleep; host rewrites it afterwards
// - after reset pin 0 outputs code 0x00, a 1 MHz clock, positive
// - after reset pins 1-4 output codes 0x27 to 0x2a, positive
// - after reset pin 5 is an input with code 0x90, firing nothing
// - queue-nonempty high with bytes queued, low during queue overflow
// - queue-threshold high above threshold, on full frame, or on overflow
// - frame-delimiter flag set on delimiter, cleared on leaving receive/transmit
// - an input pin fires one of 16 strobes chosen by low seven bits
// - polarity bit 1 fires on rising edge, 0 on falling edge
// - output shows selected signal; polarity 0 inverts it
// - input codes 0x00 to 0x07 fire the first eight strobes in order
// - input codes 0x08 to 0x0f fire the second eight strobes in order
// - output code 0x00 drives a clock programmable from 50 MHz down to about 196 kHz
// - output codes 0x01 to 0x18 drive one exception flag each
// - output code 0x21 is high when any collection A flag is active
// - a pin strobe acts like the same strobe sent on the serial port
// - output code 0x22 is high when any collection B flag is active
module cfgio_top
    import cfgio_pkg::*;
#(
    parameter int QCNT_W = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              deep_sleep,
    input  wire logic              reg_wr_en,
    input  wire logic [3:0]        reg_wr_idx,
    input  wire logic [7:0]        reg_wr_data,
    input  wire logic [3:0]        reg_rd_idx,
    output logic      [7:0]        reg_rd_data,
    input  wire logic [5:0]        pin_in,
    output logic      [5:0]        pin_out,
    output logic      [5:0]        pin_oe,
    output logic      [5:0]        pin_pullup,
    output logic                   pin_drive_extra,
    output logic      [1:0]        pin_analog,
    input  wire logic [23:0]       exc_flags,
    input  wire logic [23:0]       coll_a_mask,
    input  wire logic [23:0]       coll_b_mask,
    input  wire logic [QCNT_W-1:0] rxq_count,
    input  wire logic [QCNT_W-1:0] rxq_threshold,
    input  wire logic              rxq_frame_done,
    input  wire logic              rxq_overflow,
    input  wire logic              cca,
    input  wire logic              sfd_rx_evt,
    input  wire logic              sfd_tx_evt,
    input  wire logic              rx_active,
    input  wire logic              tx_active,
    output logic      [15:0]       strobe
);

    localparam logic [7:0] FSEL_RST [6] = '{`CFGIO_RST_FSEL0, `CFGIO_RST_FSEL1,
        `CFGIO_RST_FSEL2, `CFGIO_RST_FSEL3, `CFGIO_RST_FSEL4, `CFGIO_RST_FSEL5};
    localparam logic [7:0] CLK_HALF = 8'(`CFGIO_CLK_HALF);

    logic [7:0]  fsel_q [6];
    logic [7:0]  fsel_d [6];
    logic [6:0]  elec_q, elec_d;
    logic [1:0]  analog_q, analog_d;
    logic [5:0]  pol_q, pol_d;
    logic [7:0]  clkdiv_q, clkdiv_d;
    logic [5:0]  sync1_q, sync1_d, sync2_q, sync2_d, prev_q, prev_d;
    logic [15:0] strobe_q, strobe_d;
    logic [7:0]  cnt_q, cnt_d, half;
    logic        clk_q, clk_d;
    logic        sfd_rx_q, sfd_rx_d, sfd_tx_q, sfd_tx_d;
    logic [5:0]  out_q, out_d, oe_q, oe_d, pull_q;
    logic        drive_q;
    logic [1:0]  ana_q;
    logic [7:0]  rd_q, rd_d;
    logic [5:0]  dir_in;

    // configuration registers; deep sleep holds the reset setup
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            fsel_d[i] = fsel_q[i];
        end
        elec_d   = elec_q;
        analog_d = analog_q;
        pol_d    = pol_q;
        clkdiv_d = clkdiv_q;
        if (deep_sleep) begin
            for (int i = 0; i < 6; i++) begin
                fsel_d[i] = FSEL_RST[i];
            end
            elec_d   = `CFGIO_RST_ELEC;
            analog_d = `CFGIO_RST_ANALOG;
            pol_d    = `CFGIO_RST_POL;
            clkdiv_d = CLK_HALF;
        end else if (reg_wr_en) begin
            if (reg_wr_idx <= `CFGIO_IDX_FSEL_LAST) begin
                fsel_d[reg_wr_idx[2:0]] = reg_wr_data;
            end
            case (reg_wr_idx)
                `CFGIO_IDX_ELEC:   elec_d   = reg_wr_data[6:0];
                `CFGIO_IDX_ANALOG: analog_d = reg_wr_data[1:0];
                `CFGIO_IDX_POL:    pol_d    = reg_wr_data[5:0];
                `CFGIO_IDX_CLKDIV: clkdiv_d = reg_wr_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < 6; i++) begin
                fsel_q[i] <= FSEL_RST[i];
            end
            elec_q   <= `CFGIO_RST_ELEC;
            analog_q <= `CFGIO_RST_ANALOG;
            pol_q    <= `CFGIO_RST_POL;
            clkdiv_q <= CLK_HALF;
        end else begin
            for (int i = 0; i < 6; i++) begin
                fsel_q[i] <= fsel_d[i];
            end
            elec_q   <= elec_d;
            analog_q <= analog_d;
            pol_q    <= pol_d;
            clkdiv_q <= clkdiv_d;
        end
    end

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            dir_in[i] = fsel_q[i][`CFGIO_DIR_BIT];
        end
    end

    // two-stage synchroniser, then edge detect on stage two only
    always_comb begin
        sync1_d  = pin_in;
        sync2_d  = sync1_q;
        prev_d   = sync2_q;
        strobe_d = 16'h0000;
        for (int i = 0; i < 6; i++) begin
            if (dir_in[i] && fsel_q[i][6:4] == 3'h0 &&
                (pol_q[i] ? (sync2_q[i] && !prev_q[i])
                          : (!sync2_q[i] && prev_q[i]))) begin
                strobe_d[fsel_q[i][3:0]] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1_q  <= 6'h00;
            sync2_q  <= 6'h00;
            prev_q   <= 6'h00;
            strobe_q <= 16'h0000;
        end else begin
            sync1_q  <= sync1_d;
            sync2_q  <= sync2_d;
            prev_q   <= prev_d;
            strobe_q <= strobe_d;
        end
    end

    // clock output divider; half period below one cycle is clamped to one
    always_comb begin
        half  = (clkdiv_q == 8'h00) ? 8'h01 : clkdiv_q;
        cnt_d = cnt_q + 8'h01;
        clk_d = clk_q;
        if (cnt_q >= half - 8'h01) begin
            cnt_d = 8'h00;
            clk_d = !clk_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_q <= 8'h00;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    // delimiter flags; a new delimiter wins over the clear on leaving
    always_comb begin
        sfd_rx_d = (sfd_rx_q && rx_active) || sfd_rx_evt;
        sfd_tx_d = (sfd_tx_q && tx_active) || sfd_tx_evt;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sfd_rx_q <= 1'b0;
            sfd_tx_q <= 1'b0;
        end else begin
            sfd_rx_q <= sfd_rx_d;
            sfd_tx_q <= sfd_tx_d;
        end
    end

    // internal signal selected by an output function code
    function automatic logic sig_sel(input cfgio_code_type c);
        logic [4:0] ei;
        ei = 5'(c - `CFGIO_C_EXC_FIRST);
        if (c >= `CFGIO_C_EXC_FIRST && c <= `CFGIO_C_EXC_LAST) begin
            return exc_flags[ei];
        end
        case (c)
            `CFGIO_C_CLK:     return clk_q;
            `CFGIO_C_CHAN_A:  return |(exc_flags & coll_a_mask);
            `CFGIO_C_CHAN_B:  return |(exc_flags & coll_b_mask);
            `CFGIO_C_NCHAN_A: return |(exc_flags & ~coll_a_mask);
            `CFGIO_C_NCHAN_B: return |(exc_flags & ~coll_b_mask);
            `CFGIO_C_RX_ERR:  return |(exc_flags & `CFGIO_RX_ERR_MASK);
            `CFGIO_C_GEN_ERR: return |(exc_flags & `CFGIO_GEN_ERR_MASK);
            `CFGIO_C_RXQ_NE:  return (rxq_count != '0) && !rxq_overflow;
            `CFGIO_C_RXQ_THR: return (rxq_count > rxq_threshold) ||
                                     rxq_frame_done || rxq_overflow;
            `CFGIO_C_CCA:     return cca;
            `CFGIO_C_SFD:     return sfd_rx_q || sfd_tx_q;
            default:          return 1'b0;
        endcase
    endfunction

    // pin drive; registered so the pads never see decode glitches
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            oe_d[i]  = !dir_in[i];
            out_d[i] = dir_in[i] ? 1'b0
                     : (sig_sel(fsel_q[i][6:0]) ^ !pol_q[i]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_q   <= 6'h00;
            oe_q    <= 6'h00;
            pull_q  <= 6'h00;
            drive_q <= 1'b0;
            ana_q   <= 2'h0;
        end else begin
            out_q   <= out_d;
            oe_q    <= oe_d;
            pull_q  <= elec_q[5:0];
            drive_q <= elec_q[`CFGIO_DRIVE_BIT];
            ana_q   <= analog_q;
        end
    end

    // read port, one cycle latency; unmapped indexes read zero
    always_comb begin
        rd_d = 8'h00;
        if (reg_rd_idx <= `CFGIO_IDX_FSEL_LAST) begin
            rd_d = fsel_q[reg_rd_idx[2:0]];
        end
        case (reg_rd_idx)
            `CFGIO_IDX_ELEC:   rd_d = {1'b0, elec_q};
            `CFGIO_IDX_ANALOG: rd_d = {6'h00, analog_q};
            `CFGIO_IDX_POL:    rd_d = {2'h0, pol_q};
            `CFGIO_IDX_CLKDIV: rd_d = clkdiv_q;
            `CFGIO_IDX_PINLVL: rd_d = {2'h0, sync2_q};
            default: ;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign reg_rd_data     = rd_q;
    assign pin_out         = out_q;
    assign pin_oe          = oe_q;
    assign pin_pullup      = pull_q;
    assign pin_drive_extra = drive_q;
    assign pin_analog      = ana_q;
    assign strobe          = strobe_q;

    // checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // output enable follows the direction bit of the previous edge, both ways
    a_input_no_drive: assert property (
        !$past(reset) |-> pin_oe == ~$past(dir_in))
        else $error("pin direction not applied");

    a_reset_setup: assert property (
        $fell(reset) |-> fsel_q[0] == `CFGIO_RST_FSEL0 && fsel_q[1] == `CFGIO_RST_FSEL1
            && fsel_q[4] == `CFGIO_RST_FSEL4 && fsel_q[5] == `CFGIO_RST_FSEL5)
        else $error("reset pin setup wrong");

    a_sleep_defaults: assert property (
        deep_sleep |=> fsel_q[2] == `CFGIO_RST_FSEL2 && fsel_q[3] == `CFGIO_RST_FSEL3
            && pol_q == `CFGIO_RST_POL && elec_q == `CFGIO_RST_ELEC)
        else $error("deep sleep did not restore setup");

    a_pullup_write: assert property (
        reg_wr_en && reg_wr_idx == `CFGIO_IDX_ELEC && !deep_sleep
            |-> ##2 pin_pullup == $past(reg_wr_data[5:0], 2))
        else $error("pull-up write not applied");

    a_clock_toggle: assert property (
        $changed(clk_q) |-> $past(cnt_q) >= $past(half) - 8'h01)
        else $error("clock output toggled off period");

    a_queue_overflow: assert property (
        fsel_q[1] == 8'h27 && pol_q[1] && rxq_overflow |=> !pin_out[1])
        else $error("nonempty high during overflow");

    a_queue_thresh: assert property (
        fsel_q[2] == 8'h28 && pol_q[2] && rxq_overflow |=> pin_out[2])
        else $error("threshold low during overflow");

    a_sfd_clear: assert property (
        sfd_rx_q && !rx_active && !sfd_rx_evt |=> !sfd_rx_q)
        else $error("delimiter flag kept after receive");

    // two synchroniser edges, then the decode edge, then the pulse is seen
    a_strobe_edge: assert property (
        $rose(pin_in[5]) ##2 (fsel_q[5][7:4] == 4'h8 && pol_q[5])
            |=> strobe[$past(fsel_q[5][3:0])])
        else $error("rising edge fired no strobe");

    a_no_strobe: assert property (
        $past(dir_in & {fsel_q[5][6:4] == 3'h0, fsel_q[4][6:4] == 3'h0,
            fsel_q[3][6:4] == 3'h0, fsel_q[2][6:4] == 3'h0, fsel_q[1][6:4] == 3'h0,
            fsel_q[0][6:4] == 3'h0}) == 6'h00 |-> strobe == 16'h0000)
        else $error("strobe from a non-strobe pin");

    a_low_force: assert property (
        fsel_q[1] == {1'b0, `CFGIO_C_LOW} |=> pin_out[1] == !$past(pol_q[1]))
        else $error("reserved code not low");

    a_chan_a: assert property (
        fsel_q[1] == {1'b0, `CFGIO_C_CHAN_A} && pol_q[1] && |(exc_flags & coll_a_mask)
            |=> pin_out[1])
        else $error("collection A not shown");

    a_exc_direct: assert property (
        fsel_q[1] == 8'h05 && pol_q[1] |=> pin_out[1] == $past(exc_flags[4]))
        else $error("exception flag not shown");

    c_strobe_fired: cover property (strobe != 16'h0000);
    c_sleep_exit:   cover property ($fell(deep_sleep));
    c_clock_rise:   cover property (fsel_q[0] == 8'h00 && $rose(pin_out[0]));

endmodule // cfgio_top
`default_nettype wire

// ---- bench/cfgio_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// host microcontroller at the far side of the six pins
module cfgio_host_model (
    input  wire logic       clk_sys,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] pin_pullup,
    input  wire logic [5:0] host_en,
    input  wire logic [5:0] host_drv,
    output logic      [5:0] pin_in
);
    logic [5:0] float_q = 6'h00;

    // a pin nobody drives wanders, it never keeps its last level
    always_ff @(posedge clk_sys) begin
        float_q <= ~float_q;
    end

    // wire level: block first, then host, then pull-up; host parks pins low
    // before a direction change
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (host_en[i]) begin
                pin_in[i] = host_drv[i];
            end else if (pin_pullup[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = float_q[i];
            end
        end
    end
endmodule // cfgio_host_model
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb import cfgio_pkg::*;;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        deep_sleep = 1'b0;
    logic        reg_wr_en = 1'b0;
    logic [3:0]  reg_wr_idx = 4'h0;
    logic [7:0]  reg_wr_data = 8'h00;
    logic [3:0]  reg_rd_idx = 4'h0;
    logic [7:0]  reg_rd_data;
    logic [5:0]  pin_in, pin_out, pin_oe, pin_pullup;
    logic        pin_drive_extra;
    logic [1:0]  pin_analog;
    logic [23:0] exc_flags = 24'h000000;
    logic [23:0] coll_a_mask = 24'h000000;
    logic [23:0] coll_b_mask = 24'h000000;
    logic [7:0]  rxq_count = 8'h00;
    logic [7:0]  rxq_threshold = 8'h04;
    logic        rxq_frame_done = 1'b0;
    logic        rxq_overflow = 1'b0;
    logic        cca = 1'b0;
    logic        sfd_rx_evt = 1'b0;
    logic        sfd_tx_evt = 1'b0;
    logic        rx_active = 1'b0;
    logic        tx_active = 1'b0;
    logic [15:0] strobe;
    logic [5:0]  host_en = 6'h3f;
    logic [5:0]  host_drv = 6'h00;
    logic [7:0]  rstv [6] = '{8'h00, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h90};
    int          bad_count = 0;
    int          check_count = 0;

    cfgio_top #(.QCNT_W(8)) i_dut (
        .clk_sys(clk_sys), .reset(reset), .deep_sleep(deep_sleep),
        .reg_wr_en(reg_wr_en), .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data),
        .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .pin_drive_extra(pin_drive_extra), .pin_analog(pin_analog),
        .exc_flags(exc_flags), .coll_a_mask(coll_a_mask), .coll_b_mask(coll_b_mask),
        .rxq_count(rxq_count), .rxq_threshold(rxq_threshold),
        .rxq_frame_done(rxq_frame_done), .rxq_overflow(rxq_overflow), .cca(cca),
        .sfd_rx_evt(sfd_rx_evt), .sfd_tx_evt(sfd_tx_evt), .rx_active(rx_active),
        .tx_active(tx_active), .strobe(strobe));

    cfgio_host_model i_host (
        .clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .host_en(host_en), .host_drv(host_drv),
        .pin_in(pin_in));

    // 100 MHz system clock
    always begin
        #5 clk_sys = ~clk_sys;
    end

    // all stimulus changes 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write pulse, no handshake on this port; an idle edge follows
    // so a second write never re-raises the strobe in the same time step
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        reg_wr_en = 1'b1;
        reg_wr_idx = idx;
        reg_wr_data = d;
        tick(1);
        reg_wr_en = 1'b0;
        tick(1);
    endtask

    // read data is registered one edge after the index is set
    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        reg_rd_idx = idx;
        tick(1);
        chk("register", exp, reg_rd_data);
    endtask

    task automatic pin(input int i, input logic e);
        tick(2);
        chk("pin level", e, pin_out[i]);
    endtask

    // host drives an edge, then every strobe pulse in the next cycles is counted
    task automatic fire(input int p, input logic lvl, input logic [15:0] exp);
        int n;
        n = 0;
        host_drv[p] = lvl;
        repeat (8) begin
            tick(1);
            if (strobe !== 16'h0000) begin
                n++;
                chk("strobe", exp, strobe);
            end
        end
        chk("strobe pulse count", (exp != 16'h0000) ? 1 : 0, n);
    endtask

    // measures one high phase of the clock output on pin 0
    task automatic half(input logic [31:0] exp);
        int n;
        n = 0;
        while (pin_out[0] !== 1'b0 && n < 400) begin
            tick(1);
            n++;
        end
        while (pin_out[0] !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        n = 0;
        while (pin_out[0] === 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        chk("clock half period", exp, n);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // a run needs under a thousand cycles; a hang is cut at 20000
    initial begin
        #200000;
        bad_count++;
        test_done;
    end

    initial begin
        tick(20);
        reset = 1'b0;
        tick(2);
        // reset configuration of the six pins
        for (int i = 0; i < 6; i++) begin
            rd(i[3:0], rstv[i]);
        end
        chk("direction", 6'h1f, pin_oe);
        chk("electrical", 7'h00, {pin_drive_extra, pin_pullup});
        rd(4'h8, 8'h3f);
        rd(4'hb, 8'h00);
        half(50);
        wr(4'h9, 8'h03);
        half(3);
        // electrical settings, unused bits read back as zero
        wr(4'h6, 8'hff);
        rd(4'h6, 8'h7f);
        chk("pull-ups and drive", 7'h7f, {pin_drive_extra, pin_pullup});
        wr(4'h7, 8'hff);
        rd(4'h7, 8'h03);
        chk("analog select", 2'h3, pin_analog);
        wr(4'h6, 8'h00);
        // receive queue, channel clear and delimiter signals on pins 1 to 4
        pin(1, 1'b0);
        rxq_count = 8'h01;
        pin(1, 1'b1);
        rxq_overflow = 1'b1;
        pin(1, 1'b0);
        pin(2, 1'b1);
        rxq_overflow = 1'b0;
        rxq_count = 8'h04;
        pin(2, 1'b0);
        rxq_count = 8'h05;
        pin(2, 1'b1);
        rxq_count = 8'h01;
        rxq_frame_done = 1'b1;
        pin(2, 1'b1);
        cca = 1'b1;
        pin(3, 1'b1);
        rx_active = 1'b1;
        sfd_rx_evt = 1'b1;
        tick(1);
        sfd_rx_evt = 1'b0;
        pin(4, 1'b1);
        rx_active = 1'b0;
        pin(4, 1'b0);
        tx_active = 1'b1;
        sfd_tx_evt = 1'b1;
        tick(1);
        sfd_tx_evt = 1'b0;
        pin(4, 1'b1);
        tx_active = 1'b0;
        pin(4, 1'b0);
        // inverted indication on pin 1
        wr(4'h8, 8'h3d);
        pin(1, 1'b0);
        wr(4'h8, 8'h3f);
        // every single exception flag code, set and cleared
        for (int c = 1; c <= 24; c++) begin
            wr(4'h1, c[7:0]);
            exc_flags = 24'h000001 << (c - 1);
            pin(1, 1'b1);
            exc_flags = ~(24'h000001 << (c - 1));
            pin(1, 1'b0);
        end
        // collection A on pin 1, collection B on pin 2
        wr(4'h1, 8'h21);
        wr(4'h2, 8'h22);
        coll_a_mask = 24'h000008;
        coll_b_mask = 24'h000010;
        exc_flags = 24'h000008;
        pin(1, 1'b1);
        pin(2, 1'b0);
        exc_flags = 24'h000010;
        pin(1, 1'b0);
        pin(2, 1'b1);
        // reserved code gives low before the inversion
        wr(4'h1, 8'h7e);
        pin(1, 1'b0);
        wr(4'h8, 8'h3d);
        pin(1, 1'b1);
        wr(4'h8, 8'h3f);
        pin(1, 1'b0);
        // turning pin 1 into an input must not fire anything
        wr(4'h1, 8'h8f);
        fire(1, 1'b0, 16'h0000);
        chk("direction", 6'h1d, pin_oe);
        fire(1, 1'b1, 16'h8000);
        fire(1, 1'b0, 16'h0000);
        // all sixteen strobe codes on pin 5, rising edge
        for (int k = 0; k < 16; k++) begin
            wr(4'h5, 8'h80 | k[7:0]);
            fire(5, 1'b1, 16'h0001 << k);
            fire(5, 1'b0, 16'h0000);
        end
        // falling edge selected by a cleared polarity bit
        wr(4'h8, 8'h1f);
        wr(4'h5, {1'b1, 3'h0, CFGIO_S_TX_ON});
        fire(5, 1'b1, 16'h0000);
        fire(5, 1'b0, 16'h0100);
        wr(4'h5, 8'h90);
        fire(5, 1'b1, 16'h0000);
        fire(5, 1'b0, 16'h0000);
        // deep sleep restores and holds the reset setup
        wr(4'h1, 8'h29);
        deep_sleep = 1'b1;
        tick(2);
        rd(4'h1, 8'h27);
        wr(4'h1, 8'h55);
        deep_sleep = 1'b0;
        rd(4'h1, 8'h27);
        rd(4'h5, 8'h90);
        rd(4'h8, 8'h3f);
        test_done;
    end
endmodule // tb
`default_nettype wire
